// file: design/nbh_pkg.sv
// Package for the NAND asynchronous bus host controller
package nbh_pkg;
   // Request kinds from the user side
   typedef enum logic [2:0] {
      NBH_OP_CMD = 3'h0,
      NBH_OP_ADDR = 3'h1,
      NBH_OP_WRITE = 3'h2,
      NBH_OP_READ = 3'h3,
      NBH_OP_ROWADDR = 3'h4
   } nbh_op_t;

   // One user request
   typedef struct packed {
      nbh_op_t op;
      logic [7:0] data;
      logic slc;
      logic [14:0] column;
      logic [8:0] page;
      logic [11:0] block;
      logic [2:0] lun;
   } nbh_req_t;

   // Timing: strobe low and high phases of the 20 ns write/read cycle
   localparam int NBH_CLK_NS = 10;
   localparam int NBH_T_LOW_NS = 10;
   localparam int NBH_T_HIGH_NS = 10;
   localparam int NBH_LOW_CYC = (NBH_T_LOW_NS + NBH_CLK_NS - 1) / NBH_CLK_NS;
   localparam int NBH_HIGH_CYC = (NBH_T_HIGH_NS + NBH_CLK_NS - 1) / NBH_CLK_NS;
   localparam logic [3:0] NBH_LOW_CNT = 4'(NBH_LOW_CYC);
   localparam logic [3:0] NBH_HIGH_CNT = 4'(NBH_HIGH_CYC);

   // Address space limits
   localparam logic [14:0] NBH_COL_LIMIT = 15'h48a0;
   localparam logic [11:0] NBH_BLK_LIMIT = 12'h890;
   localparam int NBH_ADDR_CYCLES = 5;

   // Status read commands accepted by a busy die
   localparam logic [7:0] NBH_CMD_STATUS = 8'h70;
   localparam logic [7:0] NBH_CMD_STATUS_ENH = 8'h78;
   localparam logic [7:0] NBH_CMD_STATUS_FIX = 8'h71;

   // Reset value of the strobes and default FIFO depth
   localparam logic NBH_STROBE_IDLE = 1'b1;
   localparam int NBH_FIFO_DEPTH = 16;
endpackage : nbh_pkg

// file: design/nbh_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module nbh_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RST,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic full;
   logic empty;

   // Pointer compare gives honest full and empty
   assign empty = (wr_q == rd_q);
   assign full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = mem_q[rd_q[AW-1:0]];

   // Write side
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         wr_q <= '0;
      end else if (i_in_valid && !full) begin
         mem_q[wr_q[AW-1:0]] <= i_in_data;
         wr_q <= wr_q + 1'b1;
      end
   end

   // Read side
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         rd_q <= '0;
      end else if (i_out_ready && !empty) begin
         rd_q <= rd_q + 1'b1;
      end
   end
endmodule : nbh_fifo

// file: design/nbh_host.sv
// Host controller driving the NAND asynchronous multiplexed bus
`timescale 1ns/1ps
module nbh_host
   import nbh_pkg::*;
#(
   parameter int FIFO_DEPTH = 16,
   parameter int NUM_TARGETS = 2
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RST,
   input wire logic i_req_valid,
   output logic o_req_ready,
   input wire nbh_pkg::nbh_req_t i_req,
   input wire logic [$clog2(NUM_TARGETS)-1:0] i_target,
   input wire logic i_wp_allow,
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic [7:0] o_rd_data,
   output logic o_addr_err,
   output logic o_busy,
   output logic [NUM_TARGETS-1:0] O_CE_N,
   output logic O_CLE,
   output logic O_ALE,
   output logic O_WE_N,
   output logic O_RE_N,
   output logic O_WP_N,
   input wire logic [7:0] I_DQ,
   output logic [7:0] O_DQ,
   output logic O_DQ_OE,
   input wire logic I_RB_N
);
   import nbh_pkg::*;

   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_SETUP = 5'h02,
      S_LOW = 5'h04,
      S_HIGH = 5'h08,
      S_WAIT = 5'h10
   } nbh_state_t;

   nbh_state_t state_q;
   nbh_op_t op_q;
   logic [7:0] dq_q;
   logic [2:0] cyc_q;
   logic [2:0] ncyc_q;
   logic [39:0] row_q;
   logic [3:0] cnt_q;
   logic [7:0] rd_byte_q;
   logic rd_push_q;
   logic fifo_ready;
   logic req_ok;
   logic [39:0] pack_w;

   // Pack column and row into five address bytes for MLC or SLC
   function automatic logic [39:0] nbh_pack(input nbh_req_t r);
      logic [39:0] b;
      b = '0;
      b[7:0] = r.column[7:0];
      b[15:8] = {1'b0, r.column[14:8]};
      b[23:16] = r.page[7:0];
      if (!r.slc) begin
         b[31:24] = {r.block[6:0], r.page[8]};
         b[39:32] = {r.lun, 5'(r.block[11:7])};
      end else begin
         b[31:24] = {r.block[6:0], 1'b0};
         b[39:32] = {r.lun, 5'(r.block[11:7])};
      end
      return b;
   endfunction : nbh_pack

   // Range check on column and block index within a LUN
   function automatic logic nbh_in_range(input nbh_req_t r);
      return (r.column < NBH_COL_LIMIT) && (r.block < NBH_BLK_LIMIT);
   endfunction : nbh_in_range

   // Address bytes of the request now on the port
   assign pack_w = nbh_pack(i_req);
   assign req_ok = (i_req.op == NBH_OP_ROWADDR) ? nbh_in_range(i_req) : 1'b1;
   assign o_req_ready = (state_q == S_IDLE) && fifo_ready;
   assign o_busy = !I_RB_N;

   // Sequencer: one strobe cycle per request, five for a full address
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         state_q <= S_IDLE;
         op_q <= NBH_OP_CMD;
         dq_q <= 8'h00;
         cyc_q <= 3'h0;
         ncyc_q <= 3'h0;
         row_q <= '0;
         cnt_q <= 4'h0;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (i_req_valid && o_req_ready && req_ok) begin
                  op_q <= (i_req.op == NBH_OP_ROWADDR) ? NBH_OP_ADDR : i_req.op;
                  row_q <= pack_w;
                  dq_q <= (i_req.op == NBH_OP_ROWADDR) ? pack_w[7:0] : i_req.data;
                  ncyc_q <= (i_req.op == NBH_OP_ROWADDR) ? 3'(NBH_ADDR_CYCLES - 1) : 3'h0;
                  cyc_q <= 3'h0;
                  cnt_q <= NBH_LOW_CNT;
                  state_q <= S_SETUP;
               end
            end
            S_SETUP: begin
               state_q <= S_LOW;
            end
            S_LOW: begin
               if (cnt_q <= 4'h1) begin
                  cnt_q <= NBH_HIGH_CNT;
                  state_q <= S_HIGH;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            S_HIGH: begin
               if (cnt_q <= 4'h1) begin
                  if (cyc_q < ncyc_q) begin
                     cyc_q <= cyc_q + 3'h1;
                     dq_q <= row_q[8*(cyc_q+3'h1) +: 8];
                     cnt_q <= NBH_LOW_CNT;
                     state_q <= S_LOW;
                  end else begin
                     state_q <= S_WAIT;
                  end
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            S_WAIT: begin
               state_q <= S_IDLE;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // Pins: strobes idle high; CLE/ALE per op; only selected target enabled
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         O_CE_N <= '1;
         O_CLE <= 1'b0;
         O_ALE <= 1'b0;
         O_WE_N <= NBH_STROBE_IDLE;
         O_RE_N <= NBH_STROBE_IDLE;
         O_DQ <= 8'h00;
         O_DQ_OE <= 1'b0;
         O_WP_N <= 1'b0;
      end else begin
         O_WP_N <= i_wp_allow;
         O_DQ <= dq_q;
         if (state_q == S_IDLE && i_req_valid && o_req_ready && req_ok) begin
            O_CE_N <= ~(NUM_TARGETS'(1) << i_target);
         end else if (state_q == S_IDLE) begin
            O_CE_N <= '1;
         end
         O_CLE <= (state_q != S_IDLE) && (op_q == NBH_OP_CMD);
         O_ALE <= (state_q != S_IDLE) && (op_q == NBH_OP_ADDR);
         O_DQ_OE <= (state_q != S_IDLE) && (op_q != NBH_OP_READ);
         O_WE_N <= !((state_q == S_LOW) && (op_q != NBH_OP_READ));
         O_RE_N <= !((state_q == S_LOW) && (op_q == NBH_OP_READ));
      end
   end

   // Capture read byte at the end of the RE low phase; flag range errors
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         rd_byte_q <= 8'h00;
         rd_push_q <= 1'b0;
         o_addr_err <= 1'b0;
      end else begin
         rd_push_q <= (state_q == S_HIGH) && (op_q == NBH_OP_READ) && (cnt_q == NBH_HIGH_CNT);
         // Sample at the edge that raises RE, while the target still drives its byte
         if (state_q == S_HIGH && op_q == NBH_OP_READ && cnt_q == NBH_HIGH_CNT) begin
            rd_byte_q <= I_DQ;
         end
         o_addr_err <= (state_q == S_IDLE) && i_req_valid && o_req_ready && !req_ok;
      end
   end

   // Read data buffer; reads are held back while it is full
   nbh_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .I_SYS_CLK(I_SYS_CLK),
      .I_RST(I_RST),
      .i_in_valid(rd_push_q),
      .o_in_ready(fifo_ready),
      .i_in_data(rd_byte_q),
      .o_out_valid(o_rd_valid),
      .i_out_ready(i_rd_ready),
      .o_out_data(o_rd_data)
   );

   // Command cycle keeps ALE low, RE high and a target enabled while WE is low with CLE high
   a_cmd_levels: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      !O_WE_N && O_CLE |-> !O_ALE && O_RE_N && !(&O_CE_N)) else $error("bad command levels");
   a_addr_levels: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      !O_WE_N && O_ALE |-> !O_CLE && O_RE_N && !(&O_CE_N)) else $error("bad address levels");
   a_strobe_excl: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      !(!O_WE_N && !O_RE_N)) else $error("both strobes low");
   a_read_levels: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      !O_RE_N |-> !O_CLE && !O_ALE && !O_DQ_OE) else $error("bad read levels");
   a_col_top_low: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (state_q == S_LOW && op_q == NBH_OP_ADDR && ncyc_q != 3'h0 && cyc_q == 3'h1) |-> !dq_q[7])
      else $error("column top bit high");
   a_idle_disable: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      state_q == S_WAIT ##1 !(i_req_valid && o_req_ready && req_ok) |=> (&O_CE_N))
      else $error("target left enabled");
   a_one_target: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      $onehot0(~O_CE_N)) else $error("two targets enabled");
   a_range_err: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (state_q == S_IDLE && i_req_valid && o_req_ready && !req_ok) |=> o_addr_err && state_q == S_IDLE)
      else $error("range error not flagged");
endmodule : nbh_host

// file: tb/nbh_dev_model.sv
// Behavioural NAND target: latches bus cycles, serves read bytes, drives ready/busy
`timescale 1ns/1ps
module nbh_dev_model (
   input wire logic [1:0] i_ce_n,
   input wire logic i_cle,
   input wire logic i_ale,
   input wire logic i_we_n,
   input wire logic i_re_n,
   input wire logic [7:0] i_dq,
   input wire logic i_busy,
   output logic [7:0] o_dq,
   output logic o_rb_n
);
   logic [11:0] log_q[$];
   // Page bytes waiting for output; data and cache registers act as one here
   logic [7:0] rd_q[$];
   logic after_enh = 1'b0;
   logic [1:0] kind;
   initial o_dq = 8'h5a;
   // Ready/busy driven low while busy, driven high when idle
   assign o_rb_n = !i_busy;
   // Write strobe rise latches command, address or data; busy die filters
   always @(posedge i_we_n) begin
      if ((i_ce_n != 2'b11) && i_re_n) begin
         kind = i_cle ? (i_ale ? 2'd0 : 2'd1) : (i_ale ? 2'd2 : 2'd3);
         if (!i_busy || (kind == 2'd1 && (i_dq == 8'h70 || i_dq == 8'h78 || i_dq == 8'h71))
             || (kind == 2'd2 && after_enh)) begin
            log_q.push_back({i_ce_n, kind, i_dq});
         end
         if (kind == 2'd1) after_enh = (i_dq == 8'h78);
      end
   end
   // Read strobe fall presents the next byte
   always @(negedge i_re_n) begin
      if ((i_ce_n != 2'b11) && !i_cle && !i_ale && i_we_n && rd_q.size() > 0) o_dq = rd_q.pop_front();
   end
   // After the hold time the released bus shows the inverse of the last byte
   always @(posedge i_re_n) #3 o_dq = ~o_dq;
endmodule : nbh_dev_model

// file: tb/testbench.sv
// Self-checking bench for the NAND bus host against a target model
`timescale 1ns/1ps
module testbench;
   import nbh_pkg::*;
   logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, target = 1'b0, wp_allow = 1'b0, rd_ready = 1'b0;
   logic dev_busy = 1'b0, req_ready, rd_valid, addr_err, busy, cle, ale, we_n, re_n, wp_n, dq_oe, rb_n;
   nbh_req_t req = '0;
   logic [7:0] rd_data, dq_out, dev_dq, dq_wire;
   logic [1:0] ce_n;
   logic [11:0] exp_q[$];
   logic [7:0] rexp_q[$];
   int n_fail = 0, n_compared = 0, n_err = 0;
   integer seed = 32'h6fb3;
   always #5 clk = ~clk;
   // Resolved data bus
   assign dq_wire = dq_oe ? dq_out : dev_dq;
   nbh_host #(.FIFO_DEPTH(16), .NUM_TARGETS(2)) u_dut (.I_SYS_CLK(clk), .I_RST(rst), .i_req_valid(req_valid),
      .o_req_ready(req_ready), .i_req(req), .i_target(target), .i_wp_allow(wp_allow), .o_rd_valid(rd_valid),
      .i_rd_ready(rd_ready), .o_rd_data(rd_data), .o_addr_err(addr_err), .o_busy(busy), .O_CE_N(ce_n),
      .O_CLE(cle), .O_ALE(ale), .O_WE_N(we_n), .O_RE_N(re_n), .O_WP_N(wp_n), .I_DQ(dq_wire), .O_DQ(dq_out),
      .O_DQ_OE(dq_oe), .I_RB_N(rb_n));
   nbh_dev_model u_dev (.i_ce_n(ce_n), .i_cle(cle), .i_ale(ale), .i_we_n(we_n), .i_re_n(re_n),
      .i_dq(dq_wire), .i_busy(dev_busy), .o_dq(dev_dq), .o_rb_n(rb_n));
   // Count reject pulses
   always @(posedge clk) if (addr_err === 1'b1) n_err++;
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (exp !== got) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   function automatic logic [1:0] cex(input logic t);
      return t ? 2'b01 : 2'b10;
   endfunction : cex
   function automatic nbh_req_t mk(input nbh_op_t op, input logic [7:0] d);
      mk = '0;
      mk.op = op;
      mk.data = d;
   endfunction : mk
   // One request on the valid/ready port, then wait for the sequence to end
   task automatic send(input nbh_req_t r, input logic t);
      @(posedge clk);
      req <= r;
      target <= t;
      req_valid <= 1'b1;
      for (int k = 0; k < 40; k++) begin
         @(negedge clk);
         if (req_ready === 1'b1) break;
      end
      @(posedge clk);
      req_valid <= 1'b0;
      for (int k = 0; k < 40; k++) begin
         @(negedge clk);
         if (req_ready === 1'b1) break;
      end
      repeat (3) @(posedge clk);
   endtask : send
   // Expected bytes of a five-cycle row address
   task automatic exp_row(input nbh_req_t r, input logic t);
      // Async bus keeps column bit 0 as sent
      exp_q.push_back({cex(t), 2'd2, r.column[7:0]});
      exp_q.push_back({cex(t), 2'd2, 1'b0, r.column[14:8]});
      exp_q.push_back({cex(t), 2'd2, r.page[7:0]});
      exp_q.push_back({cex(t), 2'd2, r.block[6:0], r.slc ? 1'b0 : r.page[8]});
      exp_q.push_back({cex(t), 2'd2, r.lun, r.block[11:7]});
   endtask : exp_row
   // Compare latched cycles with the expected ones, then check the bus is idle
   task automatic cmp_log(input string what);
      chk({what, " count"}, exp_q.size(), u_dev.log_q.size());
      while (exp_q.size() > 0 && u_dev.log_q.size() > 0) chk(what, exp_q.pop_front(), u_dev.log_q.pop_front());
      exp_q.delete();
      u_dev.log_q.delete();
      chk("idle pins", 6'b111100, {ce_n, we_n, re_n, dq_oe, cle | ale});
      $display("test %s done", what);
   endtask : cmp_log
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict
   // Watchdog against a hang
   initial begin
      #200000;
      n_fail++;
      give_verdict();
   end
   initial begin
      nbh_req_t r;
      logic t;
      logic [7:0] b;
      int k;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("reset pins", 8'hcc, {ce_n, cle, ale, we_n, re_n, dq_oe, wp_n});
      // Single command, address and data cycles on random targets
      for (int i = 0; i < 9; i++) begin
         b = 8'($random(seed));
         t = 1'($random(seed));
         send(mk(nbh_op_t'(3'(i % 3)), b), t);
         exp_q.push_back({cex(t), 2'(i % 3 + 1), b});
      end
      cmp_log("single cycles");
      // Row addresses in both modes, last one at the top of the range
      for (int i = 0; i < 8; i++) begin
         r = mk(NBH_OP_ROWADDR, 8'h00);
         r.slc = i[0];
         r.column = (i == 7) ? 15'h489f : 15'($unsigned($random(seed)) % 18592);
         r.page = 9'($random(seed));
         r.block = (i == 7) ? 12'd2191 : 12'($unsigned($random(seed)) % 2192);
         r.lun = 3'($random(seed));
         send(r, 1'(i >> 1));
         exp_row(r, 1'(i >> 1));
      end
      cmp_log("row address");
      // Out-of-range rows are refused with one pulse and no bus cycles
      for (int i = 0; i < 4; i++) begin
         r = mk(NBH_OP_ROWADDR, 8'h00);
         r.column = i[1] ? 15'h0 : (i[0] ? 15'h7fff : 15'h48a0);
         r.block = i[1] ? (i[0] ? 12'hfff : 12'd2192) : 12'h0;
         k = n_err;
         send(r, 1'b0);
         chk("reject pulse", k + 1, n_err);
      end
      cmp_log("rejects");
      // Status reads and enhanced-status address while busy
      @(posedge clk) dev_busy <= 1'b1;
      repeat (2) @(posedge clk);
      chk("busy flag", 1, busy);
      send(mk(NBH_OP_CMD, 8'h78), 1'b0);
      send(mk(NBH_OP_ADDR, 8'h03), 1'b0);
      send(mk(NBH_OP_CMD, 8'h70), 1'b0);
      send(mk(NBH_OP_CMD, 8'h71), 1'b0);
      exp_q = '{{2'b10, 2'd1, 8'h78}, {2'b10, 2'd2, 8'h03}, {2'b10, 2'd1, 8'h70}, {2'b10, 2'd1, 8'h71}};
      dev_busy <= 1'b0;
      cmp_log("busy status");
      // Fill the read buffer until refused, then drain with random stalls
      for (int i = 0; i < 16; i++) begin
         b = 8'($random(seed));
         u_dev.rd_q.push_back(b);
         rexp_q.push_back(b);
         send(mk(NBH_OP_READ, 8'h00), 1'b1);
      end
      chk("full refuses", 0, req_ready);
      for (int i = 0; i < 100 && rexp_q.size() > 0; i++) begin
         @(posedge clk) rd_ready <= 1'($random(seed));
         @(negedge clk);
         if (rd_valid === 1'b1 && rd_ready) chk("read byte", rexp_q.pop_front(), rd_data);
      end
      @(posedge clk) rd_ready <= 1'b0;
      repeat (3) @(posedge clk);
      chk("drained", 0, {rd_valid, 7'(rexp_q.size())});
      cmp_log("reads");
      // Write protect follows the allow input
      for (int i = 0; i < 2; i++) begin
         @(posedge clk) wp_allow <= ~i[0];
         repeat (3) @(posedge clk);
         chk("write protect", !i[0], wp_n);
      end
      give_verdict();
   end
endmodule : testbench
